// [rtl/pmc_pkg.sv]
// power mode controller constants, register map and types
package pmc_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_STOP_IDLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int SRC_LSB = 0;
  localparam int SLEEP_SEL_BIT = 4;
  localparam int FAIL_MON_BIT = 7;
  localparam int CUR_SRC_LSB = 12;
  localparam int DIV_LSB = 19;
  localparam int ST_BUSY_BIT = 4;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic SLEEP_SEL_RST = 1'b0;
  localparam logic FAIL_MON_RST = 1'b1;
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam int NUM_PERIPH = 8;
  localparam int CNT_W = 12;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_START_NS = 1000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_FAST_INTERNAL_OSC = 3'h0,
    SRC_FAST_INTERNAL_OSC_DIV = 3'h1,
    SRC_PRIMARY_OSC = 3'h2,
    SRC_PRIMARY_OSC_PLL = 3'h3,
    SRC_SECONDARY_OSC = 3'h4,
    SRC_LOW_POWER_INTERNAL_OSC = 3'h5
  } pmc_src_t;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } pmc_state_t;
endpackage

// [rtl/pmc_top.sv]
// power mode controller: run, idle and sleep sequencing with clock gating
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module pmc_top #(
  parameter int NPER = pmc_pkg::NUM_PERIPH,
  parameter int OSC_START = pmc_pkg::OSC_START_CYC,
  parameter int PLL_LOCK = pmc_pkg::PLL_LOCK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // core and interrupt controller
  input wire logic wait_exec,
  input wire logic [2:0] cpu_priority,
  input wire logic irq_valid,
  input wire logic [2:0] irq_priority,
  input wire logic irq_sleep_src,
  input wire logic wdt_timeout,
  input wire logic reset_event,
  input wire logic usb_osc_req,
  input wire logic [NPER-1:0] periph_own_clk,
  // clock gating and status
  output logic cpu_clk_en,
  output logic system_clock_main_en,
  output logic peripheral_bus_clock_en,
  output logic [NPER-1:0] periph_run,
  output logic fail_mon_en,
  output logic brownout_en,
  output logic [2:0] clk_src_sel,
  output logic cpu_wake,
  output logic [3:0] power_mode
);
  import pmc_pkg::*;

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  pmc_state_t state_q, state_d;
  logic [2:0] req_src_q, cur_src_q, sw_tgt_q;
  logic sleep_sel_q, fail_mon_q, sw_busy_q, wake_idle_q;
  logic [1:0] div_q;
  logic [NPER-1:0] stop_idle_q, periph_run_q;
  logic [CNT_W-1:0] sw_cnt_q, wake_cnt_q;
  logic [2:0] div_cnt_q;
  logic [31:0] rdata_q, osc_rd;
  logic cpu_clk_en_q, system_clock_main_en_q, peripheral_bus_clock_en_q, fail_mon_en_q;
  logic hi_irq, hi_sleep, lo_sleep, exit_evt, clk_good_d, usb_keep, brownout_en_q, cpu_wake_q;
  logic [CNT_W-1:0] wake_delay;
  logic [2:0] div_mask;

  // crystal sources need start-up, the pll adds its lock time on top
  function automatic logic [CNT_W-1:0] src_delay(input logic [2:0] src);
    logic [CNT_W-1:0] d;
    d = '0;
    case (src)
      SRC_PRIMARY_OSC, SRC_SECONDARY_OSC: d = CNT_W'(OSC_START);
      SRC_PRIMARY_OSC_PLL: d = CNT_W'(OSC_START + PLL_LOCK);
      default: d = '0;
    endcase
    return d;
  endfunction

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_src_q <= SRC_RST;
      sleep_sel_q <= SLEEP_SEL_RST;
      fail_mon_q <= FAIL_MON_RST;
      div_q <= DIV_RST;
    end else if (reg_wr && reg_addr == OFS_OSC_CTRL) begin
      req_src_q <= reg_wdata[SRC_LSB+:3];
      sleep_sel_q <= reg_wdata[SLEEP_SEL_BIT];
      fail_mon_q <= reg_wdata[FAIL_MON_BIT];
      div_q <= reg_wdata[DIV_LSB+:2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_idle_q <= '0;
    end else if (reg_wr && reg_addr == OFS_STOP_IDLE) begin
      stop_idle_q <= reg_wdata[NPER-1:0];
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_comb begin
    osc_rd = '0;
    osc_rd[SRC_LSB+:3] = req_src_q;
    osc_rd[SLEEP_SEL_BIT] = sleep_sel_q;
    osc_rd[FAIL_MON_BIT] = fail_mon_q;
    osc_rd[CUR_SRC_LSB+:3] = cur_src_q;
    osc_rd[DIV_LSB+:2] = div_q;
  end

  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_OSC_CTRL: rdata_q <= osc_rd;
        OFS_STOP_IDLE: rdata_q <= 32'(stop_idle_q);
        OFS_STATUS: rdata_q <= {27'h0, sw_busy_q, state_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // ------------------------------------------------------------
  // mode sequencing
  // ------------------------------------------------------------
  assign hi_irq = irq_valid && (irq_priority > cpu_priority);
  assign hi_sleep = hi_irq && irq_sleep_src;
  assign lo_sleep = irq_valid && irq_sleep_src && !hi_irq;
  assign exit_evt = wdt_timeout || reset_event;
  // a source the usb kept alive through sleep needs no start-up on wake
  assign wake_delay = system_clock_main_en_q ? '0 : src_delay(cur_src_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (wait_exec) begin
          state_d = sleep_sel_q ? ST_SLEEP : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (hi_irq || exit_evt) begin
          state_d = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (hi_sleep || exit_evt || lo_sleep) begin
          if (wake_delay != '0) begin
            state_d = ST_WAKE;
          end else begin
            state_d = (hi_sleep || exit_evt) ? ST_RUN : ST_IDLE;
          end
        end
      end
      ST_WAKE: begin
        if (wake_cnt_q == CNT_W'(1)) begin
          state_d = (wake_idle_q && !hi_irq && !exit_evt) ? ST_IDLE : ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // sleep entry leaves the watchdog alone: no clear is issued here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_cnt_q <= '0;
      wake_idle_q <= 1'b0;
    end else if (state_q == ST_SLEEP && state_d == ST_WAKE) begin
      wake_cnt_q <= wake_delay;
      wake_idle_q <= !(hi_sleep || exit_evt);
    end else if (state_q == ST_WAKE) begin
      wake_cnt_q <= wake_cnt_q - CNT_W'(1);
      if (hi_irq || exit_evt) begin
        wake_idle_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // clock source switching
  // ------------------------------------------------------------
  // the switch only advances in run; it pauses while the core is halted
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_src_q <= SRC_RST;
      sw_tgt_q <= SRC_RST;
      sw_busy_q <= 1'b0;
      sw_cnt_q <= '0;
    end else if (state_q == ST_RUN) begin
      if (sw_busy_q) begin
        sw_cnt_q <= sw_cnt_q - CNT_W'(1);
        if (sw_cnt_q == CNT_W'(1)) begin
          cur_src_q <= sw_tgt_q;
          sw_busy_q <= 1'b0;
        end
      end else if (req_src_q != cur_src_q) begin
        if (src_delay(req_src_q) == '0) begin
          cur_src_q <= req_src_q;
        end else begin
          sw_tgt_q <= req_src_q;
          sw_cnt_q <= src_delay(req_src_q);
          sw_busy_q <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // clock gating outputs
  // ------------------------------------------------------------
  assign usb_keep = usb_osc_req && (cur_src_q inside {SRC_PRIMARY_OSC, SRC_PRIMARY_OSC_PLL,
    SRC_FAST_INTERNAL_OSC, SRC_FAST_INTERNAL_OSC_DIV});
  assign clk_good_d = (state_d == ST_RUN) || (state_d == ST_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_clk_en_q <= 1'b1;
      system_clock_main_en_q <= 1'b1;
      fail_mon_en_q <= FAIL_MON_RST;
      brownout_en_q <= 1'b1;
      cpu_wake_q <= 1'b0;
    end else begin
      cpu_clk_en_q <= (state_d == ST_RUN);
      system_clock_main_en_q <= (state_d != ST_SLEEP) || usb_keep;
      fail_mon_en_q <= fail_mon_q && (state_d != ST_SLEEP);
      brownout_en_q <= 1'b1;
      cpu_wake_q <= (state_d == ST_RUN) && (state_q != ST_RUN);
    end
  end

  // peripheral bus divider: one enable every 1, 2, 4 or 8 system cycles
  assign div_mask = 3'(({1'b0, 3'h1} << div_q) - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_cnt_q <= '0;
      peripheral_bus_clock_en_q <= 1'b0;
    end else if (clk_good_d) begin
      div_cnt_q <= div_cnt_q + 3'h1;
      peripheral_bus_clock_en_q <= ((div_cnt_q & div_mask) == div_mask);
    end else begin
      div_cnt_q <= '0;
      peripheral_bus_clock_en_q <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++) begin : g_per
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          periph_run_q[gi] <= 1'b1;
        end else if (clk_good_d) begin
          periph_run_q[gi] <= !(state_d == ST_IDLE && stop_idle_q[gi]);
        end else begin
          periph_run_q[gi] <= periph_own_clk[gi];
        end
      end
    end
  endgenerate

  assign reg_rdata = rdata_q;
  assign cpu_clk_en = cpu_clk_en_q;
  assign system_clock_main_en = system_clock_main_en_q;
  assign peripheral_bus_clock_en = peripheral_bus_clock_en_q;
  assign periph_run = periph_run_q;
  assign fail_mon_en = fail_mon_en_q;
  assign brownout_en = brownout_en_q;
  assign clk_src_sel = cur_src_q;
  assign cpu_wake = cpu_wake_q;
  assign power_mode = state_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_idle_entry;
    (state_q == ST_RUN && wait_exec && !sleep_sel_q) |=> (state_q == ST_IDLE);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("wait did not enter idle");

  property p_sleep_entry;
    (state_q == ST_RUN && wait_exec && sleep_sel_q) |=> (state_q == ST_SLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("wait did not enter sleep");

  property p_cpu_halt;
    (state_q != ST_RUN) |-> !cpu_clk_en_q;
  endproperty
  a_cpu_halt: assert property (p_cpu_halt) else $error("core clock runs while halted");

  property p_idle_src;
    (state_q == ST_IDLE) |-> system_clock_main_en_q;
  endproperty
  a_idle_src: assert property (p_idle_src) else $error("source stopped in idle");
  property p_sleep_stop;
    (state_q == ST_SLEEP && !$past(usb_osc_req)) |->
      (!system_clock_main_en_q && !peripheral_bus_clock_en_q);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("clock alive in sleep");

  property p_fail_mon;
    (state_q == ST_SLEEP) |-> (!fail_mon_en_q && brownout_en_q);
  endproperty
  a_fail_mon: assert property (p_fail_mon) else $error("monitor state wrong in sleep");

  property p_sleep_low_irq;
    (state_q == ST_SLEEP && lo_sleep && !exit_evt && wake_delay == '0) |=> (state_q == ST_IDLE);
  endproperty
  a_sleep_low_irq: assert property (p_sleep_low_irq) else $error("low irq not to idle");

  property p_sleep_exit;
    (state_q == ST_SLEEP && (hi_sleep || exit_evt)) |=> (state_q inside {ST_RUN, ST_WAKE});
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");

  property p_idle_hold;
    (state_q == ST_IDLE && !hi_irq && !exit_evt) |=> (state_q == ST_IDLE);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without cause");

  property p_idle_exit;
    (state_q == ST_IDLE && (hi_irq || exit_evt)) |=> (state_q == ST_RUN) ##0 cpu_clk_en_q;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit not immediate");

  property p_switch_hold;
    (state_q == ST_RUN && sw_busy_q && sw_cnt_q > CNT_W'(1)) |=> $stable(cur_src_q);
  endproperty
  a_switch_hold: assert property (p_switch_hold) else $error("source used before ready");
  property p_div_one;
    (div_q == 2'h0 && clk_good_d) |=> peripheral_bus_clock_en_q;
  endproperty
  a_div_one: assert property (p_div_one) else $error("1:1 divider missed a cycle");

  c_idle_wake: cover property (state_q == ST_IDLE ##1 state_q == ST_RUN);
  c_sleep_to_idle: cover property (state_q == ST_SLEEP ##1 state_q == ST_IDLE);
  c_wake_delay: cover property (state_q == ST_WAKE ##1 state_q == ST_RUN);
  c_switch: cover property (sw_busy_q ##1 !sw_busy_q);
endmodule

// [verif/pmc_core_model.sv]
// core and interrupt controller model facing the power mode controller
`timescale 1ns/10ps
module pmc_core_model (
  // clock and wake feedback
  input wire logic clk,
  input wire logic cpu_wake,
  // core and interrupt controller requests
  output logic wait_exec,
  output logic [2:0] cpu_priority,
  output logic irq_valid,
  output logic [2:0] irq_priority,
  output logic irq_sleep_src
);
  initial begin
    wait_exec = 1'b0;
    cpu_priority = 3'h3;
    irq_valid = 1'b0;
    irq_priority = 3'h0;
    irq_sleep_src = 1'b0;
  end
  // the core runs a one-cycle wait instruction
  task do_wait();
    @(posedge clk);
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
  endtask
  // pending interrupt stays up until the core is woken
  task raise(input logic [2:0] p, input logic s);
    @(posedge clk);
    irq_valid <= 1'b1;
    irq_priority <= p;
    irq_sleep_src <= s;
  endtask
  // serviced interrupt: priority lines no longer hold the old value
  always @(posedge clk) begin
    if (cpu_wake === 1'b1) begin
      irq_valid <= 1'b0;
      irq_priority <= ~irq_priority;
    end
  end
endmodule

// [verif/tb.sv]
// self-checking bench for the power mode controller
`timescale 1ns/10ps
module tb;
  import pmc_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, wait_exec, irq_valid, irq_sleep_src;
  logic wdt_timeout, reset_event, usb_osc_req, cpu_clk_en, system_clock_main_en;
  logic peripheral_bus_clock_en, fail_mon_en, brownout_en, cpu_wake;
  logic [7:0] reg_addr, periph_own_clk, periph_run;
  logic [31:0] reg_wdata, reg_rdata, rd_q;
  logic [2:0] cpu_priority, irq_priority, clk_src_sel;
  logic [3:0] power_mode;
  int n_mismatch, n_tests, cyc, n;
  // ------------------------------------------------------------
  // clock, design and partner
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // short start-up and lock counts keep the run brief
  pmc_top #(.NPER(8), .OSC_START(3), .PLL_LOCK(4)) i_dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wait_exec(wait_exec), .cpu_priority(cpu_priority),
    .irq_valid(irq_valid), .irq_priority(irq_priority), .irq_sleep_src(irq_sleep_src),
    .wdt_timeout(wdt_timeout), .reset_event(reset_event), .usb_osc_req(usb_osc_req),
    .periph_own_clk(periph_own_clk), .cpu_clk_en(cpu_clk_en),
    .system_clock_main_en(system_clock_main_en),
    .peripheral_bus_clock_en(peripheral_bus_clock_en), .periph_run(periph_run),
    .fail_mon_en(fail_mon_en),
    .brownout_en(brownout_en), .clk_src_sel(clk_src_sel), .cpu_wake(cpu_wake),
    .power_mode(power_mode));
  pmc_core_model i_core (.clk(clk), .cpu_wake(cpu_wake), .wait_exec(wait_exec),
    .cpu_priority(cpu_priority), .irq_valid(irq_valid), .irq_priority(irq_priority),
    .irq_sleep_src(irq_sleep_src));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask
  task wait_mode(input logic [3:0] m, input int lim);
    #1;
    n = 0;
    while (power_mode !== m && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("power_mode", m, power_mode);
  endtask
  task cnt_pb(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      n += (peripheral_bus_clock_en === 1'b1);
    end
  endtask
  task wait_src(input logic [2:0] s);
    n = 0;
    while (clk_src_sel !== s && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // k=1 watchdog timeout, otherwise device reset request
  task pulse_in(input int k);
    @(posedge clk);
    if (k == 1) wdt_timeout <= 1'b1;
    else reset_event <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    reset_event <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd, wdt_timeout, reset_event, usb_osc_req} = 6'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    periph_own_clk = 8'h05;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("mode", ST_RUN, power_mode);
    chk("brownout", 1, brownout_en);
    rd(OFS_OSC_CTRL);
    chk("osc_ctrl", 32'h80, rd_q);
    rd(8'h0c);
    chk("unmapped", 32'h0, rd_q);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_OSC_CTRL, 32'h80 | (d << 19));
      repeat (2) @(posedge clk);
      cnt_pb(16);
      chk("pb_pulses", 16 >> d, n);
    end
    wr(OFS_OSC_CTRL, 32'h85);
    repeat (3) @(posedge clk);
    chk("src_lowpower", 5, clk_src_sel);
    wr(OFS_OSC_CTRL, 32'h82);
    wait_src(3'h2);
    chk("start_delay", 1, n >= 3);
    rd(OFS_STATUS);
    chk("status", 32'h1, rd_q);
    wr(OFS_STOP_IDLE, 32'h0f);
    i_core.do_wait();
    wait_mode(ST_IDLE, 3);
    chk("cpu_clk", 0, cpu_clk_en);
    chk("src_idle", 1, system_clock_main_en);
    chk("periph_idle", 8'hf0, periph_run);
    i_core.raise(3'h3, 1'b0);
    repeat (4) @(posedge clk);
    chk("equal_prio", ST_IDLE, power_mode);
    i_core.raise(3'h4, 1'b0);
    wait_mode(ST_RUN, 2);
    chk("wake_pulse", 1, cpu_wake);
    i_core.do_wait();
    wait_mode(ST_IDLE, 3);
    pulse_in(1);
    wait_mode(ST_RUN, 2);
    wr(OFS_OSC_CTRL, 32'h92);
    i_core.do_wait();
    wait_mode(ST_SLEEP, 3);
    chk("cpu_clk_sl", 0, cpu_clk_en);
    chk("src_sleep", 0, system_clock_main_en);
    chk("fail_mon", 0, fail_mon_en);
    chk("brownout_sl", 1, brownout_en);
    chk("periph_sl", 8'h05, periph_run);
    cnt_pb(8);
    chk("pb_sleep", 0, n);
    i_core.raise(3'h2, 1'b1);
    wait_mode(ST_IDLE, 20);
    chk("osc_restart", 1, n >= 3);
    cnt_pb(16);
    chk("pb_idle", 16, n);
    chk("cpu_held", 0, cpu_clk_en);
    i_core.raise(3'h5, 1'b1);
    wait_mode(ST_RUN, 2);
    wr(OFS_OSC_CTRL, 32'h90);
    repeat (4) @(posedge clk);
    usb_osc_req <= 1'b1;
    i_core.do_wait();
    wait_mode(ST_SLEEP, 3);
    chk("usb_keep", 1, system_clock_main_en);
    i_core.raise(3'h7, 1'b1);
    wait_mode(ST_RUN, 3);
    @(posedge clk);
    usb_osc_req <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      i_core.do_wait();
      wait_mode(ST_SLEEP, 3);
      if (k == 0) i_core.raise(3'h6, 1'b1);
      else pulse_in(k);
      wait_mode(ST_RUN, 3);
    end
    // pll source: start-up plus lock, busy flag visible meanwhile
    wr(OFS_OSC_CTRL, 32'h83);
    rd(OFS_STATUS);
    chk("status_busy", 32'h11, rd_q);
    wait_src(3'h3);
    chk("pll_delay", 1, n >= 5);
    chk("src_pll", 3, clk_src_sel);
    summarize();
  end
endmodule
